/* File: rtl/tio_pkg.sv */
// shared constants and types of the terminal i/o mode control
package tio_pkg;
   // ***************************
   // screen and memory geometry
   // ***************************
   localparam int COLS  = 74;
   localparam int LINES = 27;
   localparam int CELLS = 1998;
   localparam int CA_W  = 11;
   localparam int CODE_W = 7;
   localparam int WORD_W = 8;
   localparam int FIFO_D = 32;
   localparam int CNT_W  = 6;

   // ***************************
   // register map
   // ***************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_CMD    = 8'h04;
   localparam logic [7:0] OFS_CURSOR = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_DIV    = 8'h10;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SEND_BIT = 2;
   localparam int CTRL_TCLK_BIT = 3;
   localparam int CTRL_PLAY_BIT = 4;
   localparam int CTRL_PTX_BIT  = 5;
   localparam int CMD_XMIT_BIT  = 0;
   localparam int CMD_PRINT_BIT = 1;
   localparam int CMD_REC_BIT   = 2;
   localparam int CMD_OVF_BIT   = 3;
   localparam int CUR_Y_LSB     = 8;
   localparam int STAT_CNT_LSB  = 8;

   localparam logic [15:0] TAPE_DIV_RST = 16'h0040;

   // ***************************
   // types
   // ***************************
   typedef enum logic [1:0] {MODE_FULL, MODE_HALF, MODE_BATCH} tio_mode_e;
   typedef enum logic [1:0] {JOB_IDLE, JOB_XMIT, JOB_PRINT, JOB_REC} tio_job_e;

   typedef struct packed {
      logic              fg;
      logic [CODE_W-1:0] code;
   } tio_word_s;
endpackage

/* File: rtl/tio_mode_ctrl.sv */
// terminal i/o mode control: display memory, duplex and batch modes, print and tape
//
// Notes on behaviour
// RULE1 - full duplex: send and receive concurrently
// RULE2 - full duplex: keys go to host immediately
// RULE3 - full duplex: keys never written locally
// RULE4 - full duplex: host data displayed during sending
// RULE5 - half duplex: send or receive, never both; a word left in tx_v is still sent when full or batch turns to half receive
// RULE6 - half send: keys displayed and also sent
// RULE7 - half receive: host displayed, keys ignored
// RULE8 - batch: keyed characters stored bright
// RULE9 - batch: host chooses bright or dim
// RULE10 - one memory word per screen position
// RULE11 - transmit cycle sends untransmitted bright characters
// RULE12 - print started by operator or host
// RULE13 - print sends all unprinted characters
// RULE14 - memory contents recordable to tape
// RULE15 - playback displays, optionally forwards to host
// RULE16 - tape clock from device or tape
// RULE17 - word: seven code bits, one intensity
// RULE18 - 27 lines by 74 columns addressing
// RULE19 - per-cell transmitted and printed marks
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ns

// ***************************
// fifo
// ***************************
module tio_fifo #(
   parameter int W = 8,
   parameter int D = 32
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic                 in_valid_i,
   input  wire logic [W-1:0]         in_data_i,
   output logic                      in_ready_o,
   output logic                      out_valid_o,
   output logic [W-1:0]              out_data_o,
   input  wire logic                 out_ready_i,
   output logic [$clog2(D):0]        count_o
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       rp;
      logic [AW-1:0]       wp;
      logic [AW:0]         cnt;
   } tio_fifo_st_s;

   tio_fifo_st_s r, n;
   logic         push;
   logic         pop;

   always_comb begin
      in_ready_o  = r.cnt != (AW+1)'(D);
      out_valid_o = r.cnt != '0;
      out_data_o  = r.mem[r.rp];
      count_o     = r.cnt;
      push        = in_valid_i && in_ready_o;
      pop         = out_valid_o && out_ready_i;
      n           = r;
      if (push) begin
         n.mem[r.wp] = in_data_i;
         n.wp        = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
endmodule // tio_fifo

// ***************************
// mode control top
// ***************************
module tio_mode_ctrl
   import tio_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic [7:0]        reg_addr_i,
   input  wire logic [31:0]       reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic [31:0]            reg_rdata_o,
   input  wire logic              kb_valid_i,
   input  wire logic [CODE_W-1:0] kb_char_i,
   output logic                   kb_ready_o,
   input  wire logic              rx_valid_i,
   input  wire tio_word_s         rx_word_i,
   output logic                   rx_ready_o,
   input  wire logic              host_print_req_i,
   output logic                   tx_valid_o,
   output logic [CODE_W-1:0]      tx_char_o,
   input  wire logic              tx_ready_i,
   output logic                   prn_valid_o,
   output tio_word_s              prn_word_o,
   input  wire logic              prn_ready_i,
   input  wire logic              tape_clk_i,
   output logic                   tape_clk_o,
   output logic                   tape_clk_oe_o,
   output logic                   tape_stb_o,
   output tio_word_s              tape_word_o,
   input  wire logic              tape_dv_i,
   input  wire tio_word_s         tape_word_i
);
   typedef struct packed {
      tio_word_s [CELLS-1:0] mem;
      logic [CELLS-1:0]      txd;
      logic [CELLS-1:0]      prd;
      logic [6:0]            cur_x;
      logic [4:0]            cur_y;
      tio_mode_e             mode;
      logic                  half_send;
      logic                  clk_int;
      logic                  play_en;
      logic                  play_tx;
      logic [15:0]           div;
      logic [15:0]           divcnt;
      logic                  tclk;
      logic                  tclk_prev;
      tio_job_e              job;
      logic [CA_W-1:0]       idx;
      logic                  pend_x;
      logic                  pend_p;
      logic                  pend_r;
      logic                  ovf;
      logic                  tx_v;
      logic [CODE_W-1:0]     tx_d;
      logic                  prn_v;
      tio_word_s             prn_d;
      logic                  tape_stb;
      tio_word_s             tape_d;
      logic [31:0]           rdata;
      logic                  kb_rdy;
      logic                  rx_rdy;
      logic                  grant;
   } tio_st_s;

   // ***************************
   // helpers
   // ***************************
   function automatic logic [CA_W-1:0] cell_addr(input logic [6:0] x, input logic [4:0] y);
      cell_addr = CA_W'(int'(y) * COLS + int'(x));
   endfunction

   function automatic logic [11:0] cur_advance(input logic [6:0] x, input logic [4:0] y);
      logic [6:0] nx;
      logic [4:0] ny;
      nx = x + 7'h01;
      ny = y;
      if (int'(x) == COLS - 1) begin
         nx = '0;
         ny = (int'(y) == LINES - 1) ? 5'h00 : y + 5'h01;
      end
      cur_advance = {nx, ny};
   endfunction

   tio_st_s         r, n;
   logic            tick;
   logic            kb_acc;
   logic            rx_acc;
   logic            play_acc;
   logic            tx_allowed;
   logic            wr_en;
   tio_word_s       wr_w;
   logic [CA_W-1:0] wa;
   logic            push_v;
   tio_word_s       push_d;
   logic            scan_push;
   logic            step;
   tio_word_s       cur;
   logic            f_in_rdy;
   logic            f_out_v;
   logic [7:0]      f_out_d;
   logic            f_out_rdy;
   logic [CNT_W-1:0] f_cnt;

   tio_fifo #(
      .W (WORD_W),
      .D (FIFO_D)
   ) u_tx_fifo (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (push_v),
      .in_data_i   (push_d),
      .in_ready_o  (f_in_rdy),
      .out_valid_o (f_out_v),
      .out_data_o  (f_out_d),
      .out_ready_i (f_out_rdy),
      .count_o     (f_cnt)
   );

   // ***************************
   // next state
   // ***************************
   always_comb begin
      n          = r;
      tick       = 1'b0;
      step       = 1'b0;
      scan_push  = 1'b0;
      push_v     = 1'b0;
      push_d     = '0;
      wr_en      = 1'b0;
      wr_w       = '0;
      wa         = cell_addr(r.cur_x, r.cur_y); // RULE18
      cur        = r.mem[r.idx];
      // tape clock made here or taken from the tape unit
      n.tclk_prev = tape_clk_i;
      if (r.clk_int) begin // RULE16
         if (r.divcnt >= r.div) begin
            n.divcnt = '0;
            n.tclk   = !r.tclk;
            tick     = !r.tclk;
         end else begin
            n.divcnt = r.divcnt + 16'h0001;
         end
      end else begin
         n.divcnt = '0;
         n.tclk   = 1'b0;
         tick     = tape_clk_i && !r.tclk_prev; // RULE16
      end

      tx_allowed = !(r.mode == MODE_HALF && !r.half_send); // RULE5
      kb_acc     = kb_valid_i && r.kb_rdy;
      rx_acc     = rx_valid_i && r.rx_rdy; // RULE1 RULE4
      play_acc   = r.play_en && tick && tape_dv_i;

      // display write at the cursor; keys in half receive fall through unused
      if (play_acc) begin // RULE15
         wr_en = 1'b1;
         wr_w  = tape_word_i;
      end else if (rx_acc) begin // RULE9 RULE4
         wr_en = 1'b1;
         wr_w  = rx_word_i;
      end else if (kb_acc && (r.mode == MODE_BATCH || (r.mode == MODE_HALF && r.half_send))) begin
         wr_en = 1'b1; // RULE6 RULE3
         wr_w  = {1'b1, kb_char_i}; // RULE8 RULE17
      end

      // transmit queue: keys, then playback, then the transmit scan
      if (kb_acc && (r.mode == MODE_FULL || (r.mode == MODE_HALF && r.half_send))) begin
         push_v = f_in_rdy; // RULE2 RULE6 RULE7
         push_d = {1'b1, kb_char_i};
      end else if (play_acc && r.play_tx && tx_allowed) begin
         push_v = f_in_rdy; // RULE15
         push_d = tape_word_i;
         if (!f_in_rdy) begin
            n.ovf = 1'b1;
         end
      end

      // scan engine for transmit, print and record cycles
      n.tape_stb = 1'b0;
      if (r.prn_v && prn_ready_i) begin
         n.prn_v = 1'b0;
      end
      unique case (r.job)
         JOB_IDLE: begin
            n.idx = '0;
            if (r.pend_x) begin
               n.job    = JOB_XMIT;
               n.pend_x = 1'b0;
            end else if (r.pend_p) begin
               n.job    = JOB_PRINT;
               n.pend_p = 1'b0;
            end else if (r.pend_r && !r.play_en) begin
               n.job    = JOB_REC;
               n.pend_r = 1'b0;
            end
         end
         JOB_XMIT: begin
            if (cur.fg && !r.txd[r.idx]) begin // RULE11 RULE19
               if (!push_v && f_in_rdy && !kb_acc && tx_allowed) begin
                  scan_push      = 1'b1;
                  push_v         = 1'b1;
                  push_d         = cur;
                  n.txd[r.idx]   = 1'b1;
                  step           = 1'b1;
               end
            end else begin
               step = 1'b1;
            end
         end
         JOB_PRINT: begin
            if (!r.prd[r.idx]) begin // RULE13 RULE19
               if (!r.prn_v || prn_ready_i) begin
                  n.prn_v        = 1'b1;
                  n.prn_d        = cur;
                  n.prd[r.idx]   = 1'b1;
                  step           = 1'b1;
               end
            end else begin
               step = 1'b1;
            end
         end
         JOB_REC: begin
            if (tick) begin // RULE14
               n.tape_stb = 1'b1;
               n.tape_d   = cur;
               step       = 1'b1;
            end
         end
      endcase
      if (step) begin
         if (int'(r.idx) == CELLS - 1) begin
            n.job = JOB_IDLE;
         end else begin
            n.idx = r.idx + 11'h001;
         end
      end

      // new character clears its marks, after any scan mark
      if (wr_en) begin // RULE10
         n.mem[wa]          = wr_w;
         n.txd[wa]          = 1'b0;
         n.prd[wa]          = 1'b0;
         {n.cur_x, n.cur_y} = cur_advance(r.cur_x, r.cur_y);
      end

      // output stage of the transmit line
      f_out_rdy = (!r.tx_v || tx_ready_i) && tx_allowed; // RULE5
      if (r.tx_v && tx_ready_i) begin
         n.tx_v = 1'b0;
      end
      if (f_out_v && f_out_rdy) begin
         n.tx_v = 1'b1;
         n.tx_d = f_out_d[CODE_W-1:0];
      end

      // host print request and register writes
      if (host_print_req_i) begin
         n.pend_p = 1'b1; // RULE12
      end
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFS_CTRL: begin
               if (reg_wdata_i[CTRL_MODE_LSB+:2] != 2'h3) begin
                  n.mode = tio_mode_e'(reg_wdata_i[CTRL_MODE_LSB+:2]);
               end
               // turn from send to receive only once the line has drained
               if (reg_wdata_i[CTRL_SEND_BIT] || !(r.tx_v || f_cnt != '0)) begin
                  n.half_send = reg_wdata_i[CTRL_SEND_BIT]; // RULE5
               end
               n.clk_int = reg_wdata_i[CTRL_TCLK_BIT];
               n.play_en = reg_wdata_i[CTRL_PLAY_BIT];
               n.play_tx = reg_wdata_i[CTRL_PTX_BIT];
            end
            OFS_CMD: begin
               if (reg_wdata_i[CMD_XMIT_BIT] && r.mode == MODE_BATCH) begin
                  n.pend_x = 1'b1; // RULE11
               end
               if (reg_wdata_i[CMD_PRINT_BIT]) begin
                  n.pend_p = 1'b1; // RULE12
               end
               if (reg_wdata_i[CMD_REC_BIT]) begin
                  n.pend_r = 1'b1;
               end
               if (reg_wdata_i[CMD_OVF_BIT] && !(play_acc && r.play_tx && tx_allowed && !f_in_rdy)) begin
                  n.ovf = 1'b0;
               end
            end
            OFS_CURSOR: begin
               if (int'(reg_wdata_i[6:0]) < COLS && int'(reg_wdata_i[CUR_Y_LSB+:5]) < LINES) begin
                  n.cur_x = reg_wdata_i[6:0];
                  n.cur_y = reg_wdata_i[CUR_Y_LSB+:5];
               end
            end
            OFS_DIV: n.div = reg_wdata_i[15:0];
            default: ;
         endcase
      end

      // read data, valid only in the cycle after the strobe
      n.rdata = '0;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_CTRL: n.rdata = {26'h000_0000, r.play_tx, r.play_en, r.clk_int, r.half_send,
                                 r.mode};
            OFS_CURSOR: n.rdata = {19'h0_0000, r.cur_y, 1'b0, r.cur_x};
            OFS_STATUS: n.rdata = {18'h0_0000, f_cnt, 2'h0, r.ovf, r.pend_r, r.pend_p,
                                   r.pend_x, r.job};
            OFS_DIV: n.rdata = {16'h0000, r.div};
            default: n.rdata = '0;
         endcase
      end

      // readiness for the next cycle; batch alternates keys and host
      n.grant  = !r.grant;
      n.rx_rdy = !n.play_en && !(n.mode == MODE_HALF && n.half_send) // RULE5
                 && (n.mode != MODE_BATCH || n.grant);
      if (n.mode == MODE_HALF && !n.half_send) begin
         n.kb_rdy = !n.play_en; // RULE7
      end else if (n.mode == MODE_BATCH) begin
         n.kb_rdy = !n.play_en && !n.grant;
      end else begin
         n.kb_rdy = !n.play_en && int'(f_cnt) < FIFO_D - 2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         r     <= '0;
         r.div <= TAPE_DIV_RST;
      end else begin
         r <= n;
      end
   end

   // ***************************
   // outputs
   // ***************************
   always_comb begin
      reg_rdata_o   = r.rdata;
      kb_ready_o    = r.kb_rdy;
      rx_ready_o    = r.rx_rdy;
      tx_valid_o    = r.tx_v;
      tx_char_o     = r.tx_d;
      prn_valid_o   = r.prn_v;
      prn_word_o    = r.prn_d;
      tape_clk_o    = r.tclk;
      tape_clk_oe_o = r.clk_int;
      tape_stb_o    = r.tape_stb;
      tape_word_o   = r.tape_d;
   end

   // ***************************
   // assertions
   // ***************************
   a_half_send_rx : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE5
      (r.mode == MODE_HALF && r.half_send && !r.play_en)[*2] |-> !rx_ready_o)
      else $error("receive enabled in half duplex send state");

   a_full_kb_sent : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE2
      r.mode == MODE_FULL && kb_valid_i && kb_ready_o |-> push_v && push_d.code == kb_char_i)
      else $error("full duplex key not queued for host");

   a_full_no_local : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE3
      r.mode == MODE_FULL && kb_valid_i && kb_ready_o && !rx_acc && !play_acc
      && !reg_wr_i |=> $stable(r.cur_x) && $stable(r.cur_y))
      else $error("full duplex key written to display");

   a_full_rx_ready : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE4
      (r.mode == MODE_FULL && !r.play_en)[*3] |-> rx_ready_o)
      else $error("full duplex receive blocked");

   a_recv_kb_drop : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE7
      r.mode == MODE_HALF && !r.half_send && kb_valid_i && kb_ready_o && !play_acc
      |-> !push_v && !(wr_en && !rx_acc))
      else $error("key used in half duplex receive state");

   a_batch_kb_bright : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE8
      r.mode == MODE_BATCH && kb_valid_i && kb_ready_o && !play_acc
      |=> r.mem[$past(wa)].fg && r.mem[$past(wa)].code == $past(kb_char_i))
      else $error("batch key not stored bright");

   a_xmit_mark : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE11
      scan_push |-> push_d.fg ##1
         (r.txd[$past(r.idx)] || ($past(wr_en) && $past(wa) == $past(r.idx))))
      else $error("transmitted cell not marked");

   a_prn_hold : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE13
      prn_valid_o && !prn_ready_i |=> prn_valid_o && $stable(prn_word_o))
      else $error("printer word dropped before taken");

   a_tx_hold : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE1
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_char_o))
      else $error("host word dropped before taken");

   a_print_start : assert property (@(posedge clk_i) disable iff (!rst_b_i) // RULE12
      host_print_req_i && r.job != JOB_PRINT |=> r.pend_p || r.job == JOB_PRINT)
      else $error("host print request lost");
endmodule // tio_mode_ctrl

/* File: bench/tio_host_model.sv */
// host model: takes characters from the terminal and sends words to it
`timescale 1ns/1ns
module tio_host_model
   import tio_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              tx_valid_i,
   input  wire logic [CODE_W-1:0] tx_char_i,
   output logic                   tx_ready_o,
   output logic                   rx_valid_o,
   output tio_word_s              rx_word_o,
   input  wire logic              rx_ready_i,
   input  wire logic              stall_i,
   output logic [15:0]            got_o,
   output logic [CODE_W-1:0]      last_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_word_o  = '0;
   end
   // ***************************
   // receive side of the host
   // ***************************
   always_ff @(posedge clk_i) begin
      tx_ready_o <= rst_b_i & ~stall_i;
      if (!rst_b_i) begin
         got_o <= 16'h0000;
      end else if (tx_valid_i && tx_ready_o) begin
         got_o  <= got_o + 16'h0001;
         last_o <= tx_char_i;
      end
   end
   // ***************************
   // send side of the host
   // ***************************
   task automatic send(input tio_word_s w);
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_word_o  <= w;
      @(posedge clk_i);
      while (rx_ready_i !== 1'b1) @(posedge clk_i);
      rx_valid_o <= 1'b0;
      // released data no longer shows the old word
      rx_word_o  <= ~w;
   endtask
endmodule // tio_host_model

/* File: bench/tb.sv */
// testbench of the terminal i/o mode control
`timescale 1ns/1ns
module tb
   import tio_pkg::*;
;
   logic              clk, rst_b, reg_wr, reg_rd, kb_valid, kb_ready, rx_valid, rx_ready;
   logic [7:0]        reg_addr;
   logic [31:0]       reg_wdata, reg_rdata;
   logic [CODE_W-1:0] kb_char, tx_char, last;
   tio_word_s         rx_word, prn_word, tape_wo, tape_wi, pw, tw;
   logic              host_prq, tx_valid, tx_ready, prn_valid, prn_ready, stall;
   logic              tclk_in, tclk_out, tclk_oe, tape_stb, tape_dv;
   logic [15:0]       got;
   int                n_fail, checked, np, nt, nh, cyc;

   tio_mode_ctrl i_tio_mode_ctrl (.clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .kb_valid_i(kb_valid), .kb_char_i(kb_char), .kb_ready_o(kb_ready),
      .rx_valid_i(rx_valid), .rx_word_i(rx_word), .rx_ready_o(rx_ready),
      .host_print_req_i(host_prq), .tx_valid_o(tx_valid), .tx_char_o(tx_char),
      .tx_ready_i(tx_ready), .prn_valid_o(prn_valid), .prn_word_o(prn_word),
      .prn_ready_i(prn_ready), .tape_clk_i(tclk_in), .tape_clk_o(tclk_out),
      .tape_clk_oe_o(tclk_oe), .tape_stb_o(tape_stb), .tape_word_o(tape_wo),
      .tape_dv_i(tape_dv), .tape_word_i(tape_wi));

   tio_host_model i_tio_host_model (.clk_i(clk), .rst_b_i(rst_b), .tx_valid_i(tx_valid),
      .tx_char_i(tx_char), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_word_o(rx_word),
      .rx_ready_i(rx_ready), .stall_i(stall), .got_o(got), .last_o(last));

   always #2 clk = ~clk;

   // ***************************
   // shared tasks
   // ***************************
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask
   task automatic key(input logic [CODE_W-1:0] c);
      @(posedge clk);
      kb_valid <= 1'b1;
      kb_char  <= c;
      @(posedge clk);
      while (kb_ready !== 1'b1) @(posedge clk);
      kb_valid <= 1'b0;
   endtask
   task automatic wait_host(input logic [15:0] n);
      for (int i = 0; i < 200 && got !== n; i++) @(posedge clk);
      chk(32'(got), 32'(n));
   endtask
   task automatic wait_idle;
      logic [31:0] d;
      repeat (3) @(posedge clk);
      do rd(OFS_STATUS, d); while (d[4:0] !== 5'h00);
   endtask
   task automatic tick;
      @(posedge clk);
      tclk_in <= 1'b1;
      repeat (2) @(posedge clk);
      tclk_in <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // print and tape counters, run ceiling
   always @(posedge clk) begin
      cyc++;
      if (prn_valid === 1'b1 && prn_ready) begin
         if (np == 0) pw = prn_word;
         np++;
      end
      if (tape_stb === 1'b1) begin
         if (nt == 0) tw = tape_wo;
         nt++;
         if (tclk_out === 1'b1) nh++;
      end
      if (cyc == 40000) begin
         n_fail++;
         give_verdict();
      end
   end

   // ***************************
   // main sequence
   // ***************************
   initial begin
      {clk, rst_b, reg_wr, reg_rd, kb_valid, host_prq, tclk_in, tape_dv} = '0;
      {reg_addr, reg_wdata, kb_char, tape_wi} = '0;
      {n_fail, checked, np, nt, nh, cyc} = '0;
      prn_ready = 1'b1;
      stall     = 1'b1;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      rdc(OFS_CTRL, 32'h0000_0000);
      rdc(OFS_DIV, 32'h0000_0040);
      rdc(OFS_STATUS, 32'h0000_0000);
      rdc(8'h14, 32'h0000_0000);
      // full duplex: key held at host while host data lands
      key(7'h41);
      repeat (6) @(posedge clk);
      chk(32'({tx_valid, tx_char}), 32'h0000_00C1);
      i_tio_host_model.send(tio_word_s'(8'h61));
      rdc(OFS_CURSOR, 32'h0000_0001);
      stall <= 1'b0;
      wait_host(16'h0001);
      chk(32'(last), 32'h0000_0041);
      wr(OFS_CURSOR, 32'h0000_1A49);
      i_tio_host_model.send(tio_word_s'(8'h20));
      rdc(OFS_CURSOR, 32'h0000_0000);
      // half duplex send, then receive
      wr(OFS_CTRL, 32'h0000_0005);
      key(7'h42);
      wait_host(16'h0002);
      rdc(OFS_CURSOR, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0001);
      key(7'h5A);
      repeat (10) @(posedge clk);
      chk(32'(got), 32'h0000_0002);
      rdc(OFS_CURSOR, 32'h0000_0001);
      i_tio_host_model.send(tio_word_s'(8'h44));
      rdc(OFS_CURSOR, 32'h0000_0002);
      // batch: bright key, dim and bright host words, two transmit cycles
      wr(OFS_CTRL, 32'h0000_0002);
      wr(OFS_CURSOR, 32'h0000_0000);
      key(7'h43);
      i_tio_host_model.send(tio_word_s'(8'h44));
      i_tio_host_model.send(tio_word_s'(8'hC5));
      wr(OFS_CMD, 32'h0000_0001);
      wait_idle();
      wait_host(16'h0004);
      chk(32'(last), 32'h0000_0045);
      wr(OFS_CMD, 32'h0000_0001);
      wait_idle();
      repeat (10) @(posedge clk);
      chk(32'(got), 32'h0000_0004);
      // print by host, then by operator
      @(posedge clk);
      host_prq <= 1'b1;
      @(posedge clk);
      host_prq <= 1'b0;
      wait_idle();
      chk(32'(np), 32'd1998);
      chk(32'(pw), 32'h0000_00C3);
      key(7'h46);
      prn_ready <= 1'b0;
      wr(OFS_CMD, 32'h0000_0002);
      repeat (20) @(posedge clk);
      chk(32'(prn_valid), 32'h0000_0001);
      prn_ready <= 1'b1;
      wait_idle();
      chk(32'(np), 32'd1999);
      // record on the internal tape clock
      wr(OFS_DIV, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_000A);
      @(posedge clk);
      chk(32'(tclk_oe), 32'h0000_0001);
      wr(OFS_CMD, 32'h0000_0004);
      wait_idle();
      chk(32'(nt), 32'd1998);
      chk(32'(nh), 32'd1998);
      chk(32'(tw), 32'h0000_00C3);
      // playback on the external tape clock, forwarded to host
      wr(OFS_CTRL, 32'h0000_0030);
      wr(OFS_CURSOR, 32'h0000_0205);
      tape_wi <= tio_word_s'(8'hD0);
      tape_dv <= 1'b1;
      tick();
      tape_dv <= 1'b0;
      tape_wi <= tio_word_s'(8'h2F);
      wait_host(16'h0005);
      chk(32'(last), 32'h0000_0050);
      rdc(OFS_CURSOR, 32'h0000_0206);
      give_verdict();
   end
endmodule // tb
